// ===== shared/prs_params.svh
// constants for the program run mode sequencer
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_A_CTRL      12'h000
`define PRS_A_SEGCFG    12'h004
`define PRS_A_PRESET    12'h008
`define PRS_A_LSP       12'h00C
`define PRS_A_STATUS    12'h010
`define PRS_A_TIMER     12'h014
`define PRS_A_OUT       12'h018
`define PRS_A_SP        12'h01C
`define PRS_A_PIDSEL    12'h020
`define PRS_TICK_NS     1000000
`define PRS_CLK_NS      50
`define PRS_TICK_CYC    (`PRS_TICK_NS / `PRS_CLK_NS)
`define PRS_ZON_SEG     2'h1
`define PRS_ZON_LOCAL   2'h2
`define PRS_PID_ONE     3'h1
`define PRS_SEG_FIRST   5'h01
`define PRS_CODE_RESET  2'h0
`define PRS_CODE_RUN    2'h1
`define PRS_CODE_LOCAL  2'h2
`define PRS_F_MODE_LO   0
`define PRS_F_MODE_HI   1
`define PRS_F_MODE_STB  2
`define PRS_F_HOLD      3
`define PRS_F_HOLD_STB  4
`define PRS_F_ADV       5
`define PRS_F_MAN       6
`define PRS_F_ZON_LO    7
`define PRS_F_ZON_HI    8
`define PRS_F_LPID_LO   9
`define PRS_F_LPID_HI   11
`define PRS_F_GRP_LO    12
`define PRS_F_GRP_HI    14
`define PRS_LPID_RST    3'h1
`define PRS_GRP_RST     3'h1
`endif

// ===== shared/prs_pkg.sv
// types for the program run mode sequencer
package prs_pkg;
	typedef enum logic [1:0] {
		PRS_RESET = 2'b00,
		PRS_PROGRAM_RUN_MODE  = 2'b01,
		PRS_LOCAL = 2'b10
	} prs_mode_e;

	typedef struct packed {
		logic reset;
		logic run;
		logic local_op;
		logic hold_on;
		logic hold_off;
		logic advance;
	} prs_req_s;

	typedef struct packed {
		logic [4:0]  last_seg;
		logic [4:0]  rpt_end;
		logic [4:0]  rpt_start;
		logic        junction_code;
		logic [15:0] seg_ticks;
	} prs_seg_s;
endpackage

// ===== hw/prs_sequencer.sv
// program run mode sequencer with apb register slave
// How it works
// - reset mode stops program and local
// - reset from key, parameter, contact, comms
// - mode parameter codes reset, program, local
// - program to reset steps output to preset
// - reset to program or local is bumpless
// - reset forces pv and time events off
// - reset preset uses group one or zone
// - local zone picks configured local pid
// - hold accepted only in program operation
// - hold on pauses, hold off resumes
// - hold freezes segment and event timers
// - release resumes timers from frozen value
// - hold regulates with captured setpoint
// - hold keeps time events, pv continues
// - advance accepted only in program operation
// - advance before last segment ignores junction code, next segment
// - advance in last segment follows junction
// - advance at repeat end performs repeat
// - advance while held clears hold
// - advance ends remaining segment time
// - auto/manual setting selects control type
// - hold lamp follows hold state
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "prs_params.svh"
module prs_sequencer (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire prs_pkg::prs_req_s   key_req,
	input  wire logic                key_mode_reset,
	input  wire prs_pkg::prs_req_s   contact_req,
	input  wire prs_pkg::prs_req_s   comm_req,
	input  wire logic                ufk_is_reset,
	input  wire logic [15:0]         pid_out,
	input  wire logic [15:0]         ramp_sp,
	input  wire logic [1:0]          pv_event_in,
	input  wire logic [1:0]          time_event_in,
	output logic [15:0]              ctrl_out,
	output logic [15:0]              active_sp,
	output logic [2:0]               pid_group,
	output logic [1:0]               pv_event,
	output logic [1:0]               time_event,
	output logic [4:0]               segment,
	output logic                     hold_lamp,
	output logic                     reset_lamp,
	output logic                     manual_mode,
	output logic                     pid_run,
	output logic                     timer_run
);
	import prs_pkg::*;

	// compares a bus address with a register offset
	function automatic logic prs_hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	// widens a 16-bit register into a bus word
	function automatic logic [31:0] prs_word16(input logic [15:0] v);
		return {16'h0000, v};
	endfunction

	prs_mode_e   mode_q;
	prs_mode_e   mode_d;
	logic        hold_q;
	logic        hold_d;
	logic [4:0]  seg_q;
	logic [4:0]  seg_d;
	logic [15:0] seg_time_q;
	logic [15:0] seg_time_d;

	logic [15:0] tick_cnt_q;
	logic [15:0] hold_sp_q;
	logic [15:0] out_q;
	logic [1:0]  tev_q;
	logic        man_q;
	logic [1:0]  zon_q;
	logic [2:0]  lpid_q;
	logic [2:0]  zone_grp_q;
	logic [15:0] preset_q;
	logic [15:0] lsp_q;

	logic [1:0]  mode_par_q;
	logic        mode_par_stb_q;
	logic        hold_par_q;
	logic        hold_par_stb_q;
	logic        adv_par_q;
	prs_seg_s    segcfg_q;

	// apb decode
	wire         wr_en     = psel & penable & pwrite;
	wire         rd_sel    = psel & ~pwrite;
	wire         a_ctrl    = prs_hit(paddr, `PRS_A_CTRL);
	wire         a_segcfg  = prs_hit(paddr, `PRS_A_SEGCFG);
	wire         a_preset  = prs_hit(paddr, `PRS_A_PRESET);
	wire         a_lsp     = prs_hit(paddr, `PRS_A_LSP);
	wire         a_status  = prs_hit(paddr, `PRS_A_STATUS);
	wire         a_timer   = prs_hit(paddr, `PRS_A_TIMER);
	wire         a_out     = prs_hit(paddr, `PRS_A_OUT);
	wire         a_sp      = prs_hit(paddr, `PRS_A_SP);
	wire         a_pidsel  = prs_hit(paddr, `PRS_A_PIDSEL);
	wire         a_hit     = a_ctrl | a_segcfg | a_preset | a_lsp | a_status | a_timer
		| a_out | a_sp | a_pidsel;
	wire         ctrl_wr   = wr_en & a_ctrl;

	// control word fields as written
	wire [1:0]   wd_mode     = pwdata[`PRS_F_MODE_HI:`PRS_F_MODE_LO];
	wire         wd_mode_stb = pwdata[`PRS_F_MODE_STB];
	wire         wd_hold     = pwdata[`PRS_F_HOLD];
	wire         wd_hold_stb = pwdata[`PRS_F_HOLD_STB];
	wire         wd_adv      = pwdata[`PRS_F_ADV];
	wire         wd_man      = pwdata[`PRS_F_MAN];
	wire [1:0]   wd_zon      = pwdata[`PRS_F_ZON_HI:`PRS_F_ZON_LO];
	wire [2:0]   wd_lpid     = pwdata[`PRS_F_LPID_HI:`PRS_F_LPID_LO];
	wire [2:0]   wd_grp      = pwdata[`PRS_F_GRP_HI:`PRS_F_GRP_LO];

	// ctrl: [1:0] mode code, [2] mode strobe, [3] hold value, [4] hold strobe,
	// [5] advance, [6] manual, [8:7] zone select, [11:9] local pid, [14:12] zone group
	// read back field by field from the top bit down
	wire [31:0]  ctrl_rd = {
		17'h00000,
		zone_grp_q,
		lpid_q,
		zon_q,
		man_q,
		adv_par_q,
		1'b0,
		hold_par_q,
		1'b0,
		mode_par_q
	};

	// status: time events, segment, hold, mode
	wire [31:0]  stat_rd = {
		22'h000000,
		tev_q,
		seg_q,
		hold_q,
		mode_q
	};

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~a_hit;

	always_comb begin
		prdata = 32'h00000000;
		if (rd_sel) begin
			case (1'b1)
				a_ctrl:   prdata = ctrl_rd;
				a_segcfg: prdata = 32'(segcfg_q);
				a_preset: prdata = prs_word16(preset_q);
				a_lsp:    prdata = prs_word16(lsp_q);
				a_status: prdata = stat_rd;
				a_timer:  prdata = prs_word16(seg_time_q);
				a_out:    prdata = prs_word16(out_q);
				a_sp:     prdata = prs_word16(active_sp);
				a_pidsel: prdata = {29'h00000000, pid_group};
				default:  prdata = 32'h00000000;
			endcase
		end
	end

	// request gathering, parameter codes reset/program/local
	wire         par_reset = mode_par_stb_q & (mode_par_q == `PRS_CODE_RESET);
	wire         par_run   = mode_par_stb_q & (mode_par_q == `PRS_CODE_RUN);
	wire         par_local = mode_par_stb_q & (mode_par_q == `PRS_CODE_LOCAL);
	wire         mkey_rst  = key_mode_reset & ~ufk_is_reset;
	wire         req_reset = key_req.reset
		| par_reset
		| contact_req.reset
		| comm_req.reset
		| mkey_rst;
	wire         req_run   = key_req.run
		| par_run
		| contact_req.run
		| comm_req.run;
	wire         req_local = key_req.local_op
		| par_local
		| contact_req.local_op
		| comm_req.local_op;
	wire         in_program_run_mode   = mode_q == PRS_PROGRAM_RUN_MODE;
	wire         in_reset  = mode_q == PRS_RESET;
	wire         in_local  = mode_q == PRS_LOCAL;
	wire         req_hon   = in_program_run_mode & (key_req.hold_on | (hold_par_stb_q & hold_par_q)
		| contact_req.hold_on | comm_req.hold_on);
	wire         req_hoff  = in_program_run_mode & (key_req.hold_off | (hold_par_stb_q & ~hold_par_q)
		| contact_req.hold_off | comm_req.hold_off);
	wire         req_adv   = in_program_run_mode & (key_req.advance | adv_par_q | contact_req.advance
		| comm_req.advance);

	wire         tick      = tick_cnt_q == 16'(`PRS_TICK_CYC - 1);
	wire [15:0]  tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
	wire         seg_done  = in_program_run_mode & ~hold_q & tick & (seg_time_q == 16'h0000);
	wire         step_seg  = seg_done | req_adv;
	wire         at_last   = seg_q == segcfg_q.last_seg;
	wire         at_rpt    = seg_q == segcfg_q.rpt_end;
	wire         grp_seg   = zon_q == `PRS_ZON_SEG;
	wire         grp_loc   = zon_q == `PRS_ZON_LOCAL;

	// landing point and mode after a segment step
	wire [4:0]   seg_inc   = seg_q + 5'h01;
	wire         to_repeat = at_rpt & ~at_last;
	prs_mode_e   end_mode;
	assign end_mode = segcfg_q.junction_code ? PRS_LOCAL : PRS_RESET;

	always_comb begin
		mode_d     = mode_q;
		hold_d     = hold_q;
		seg_d      = seg_q;
		seg_time_d = seg_time_q;
		if (in_program_run_mode & ~hold_q & tick & (seg_time_q != 16'h0000)) begin
			seg_time_d = seg_time_q - 16'h0001;
		end
		if (req_hon) begin
			hold_d = 1'b1;
		end
		if (req_hoff) begin
			hold_d = 1'b0;
		end
		if (step_seg) begin
			hold_d     = 1'b0;
			seg_time_d = segcfg_q.seg_ticks;
			if (to_repeat) begin
				seg_d = segcfg_q.rpt_start;
			end else if (at_last) begin
				seg_d  = `PRS_SEG_FIRST;
				mode_d = end_mode;
			end else begin
				seg_d = seg_inc;
			end
		end
		if (req_run & (mode_q != PRS_PROGRAM_RUN_MODE)) begin
			mode_d     = PRS_PROGRAM_RUN_MODE;
			hold_d     = 1'b0;
			seg_time_d = segcfg_q.seg_ticks;
		end
		if (req_local & (mode_q != PRS_LOCAL)) begin
			mode_d = PRS_LOCAL;
			hold_d = 1'b0;
			seg_d  = `PRS_SEG_FIRST;
		end
		if (req_reset) begin
			mode_d = PRS_RESET;
			hold_d = 1'b0;
			seg_d  = `PRS_SEG_FIRST;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q     <= PRS_RESET;
			hold_q     <= 1'b0;
			seg_q      <= `PRS_SEG_FIRST;
			seg_time_q <= 16'h0000;
		end else begin
			mode_q     <= mode_d;
			hold_q     <= hold_d;
			seg_q      <= seg_d;
			seg_time_q <= seg_time_d;
		end
	end

	// free running millisecond divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// parameter strobes last one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_par_stb_q <= 1'b0;
			hold_par_stb_q <= 1'b0;
			adv_par_q      <= 1'b0;
		end else begin
			mode_par_stb_q <= ctrl_wr & wd_mode_stb;
			hold_par_stb_q <= ctrl_wr & wd_hold_stb;
			if (ctrl_wr & wd_adv) begin
				adv_par_q <= 1'b1;
			end else if (adv_par_q) begin
				adv_par_q <= 1'b0;
			end
		end
	end

	// control word fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_par_q <= `PRS_CODE_RESET;
			hold_par_q <= 1'b0;
			man_q      <= 1'b0;
			zon_q      <= 2'h0;
			lpid_q     <= `PRS_LPID_RST;
			zone_grp_q <= `PRS_GRP_RST;
		end else if (ctrl_wr) begin
			mode_par_q <= wd_mode;
			hold_par_q <= wd_hold;
			man_q      <= wd_man;
			zon_q      <= wd_zon;
			lpid_q     <= wd_lpid;
			zone_grp_q <= wd_grp;
		end
	end

	// segment table, preset and local setpoint
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			segcfg_q <= '0;
			preset_q <= 16'h0000;
			lsp_q    <= 16'h0000;
		end else begin
			if (wr_en & a_segcfg) begin
				segcfg_q <= prs_seg_s'(pwdata);
			end
			if (wr_en & a_preset) begin
				preset_q <= pwdata[15:0];
			end
			if (wr_en & a_lsp) begin
				lsp_q <= pwdata[15:0];
			end
		end
	end

	// control output: preset in reset, pid output otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 16'h0000;
		end else if (in_reset) begin
			out_q <= preset_q;
		end else begin
			out_q <= pid_out;
		end
	end

	// setpoint captured while running, frozen in hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_sp_q <= 16'h0000;
		end else if (in_program_run_mode & ~hold_q) begin
			hold_sp_q <= ramp_sp;
		end
	end

	// time events follow the engine while running, kept in hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tev_q <= 2'b00;
		end else if (in_program_run_mode & ~hold_q) begin
			tev_q <= time_event_in;
		end else if (!in_program_run_mode) begin
			tev_q <= 2'b00;
		end
	end

	assign ctrl_out    = out_q;
	assign active_sp   = in_local ? lsp_q : hold_q ? hold_sp_q : ramp_sp;
	assign pid_group   = grp_loc ? lpid_q
		: (in_reset & grp_seg) ? `PRS_PID_ONE : zone_grp_q;
	assign pv_event    = in_reset ? 2'b00 : pv_event_in;
	assign time_event  = tev_q;
	assign segment     = seg_q;
	assign hold_lamp   = hold_q;
	assign reset_lamp  = in_reset;
	assign manual_mode = man_q;
	assign pid_run     = ~in_reset;
	assign timer_run   = in_program_run_mode & ~hold_q;
endmodule

// ===== test/prs_seq_asserts.sv
// port checker for the sequencer
`timescale 1ns/1ps
module prs_seq_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [15:0] pid_out,
	input wire logic [15:0] ctrl_out,
	input wire logic [15:0] active_sp,
	input wire logic [1:0]  pv_event,
	input wire logic [1:0]  time_event,
	input wire logic        hold_lamp,
	input wire logic        reset_lamp,
	input wire logic        timer_run
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_pvo; reset_lamp |-> pv_event == 2'h0; endproperty
	a_pvo: assert property (p_pvo) else $error("pv event in reset");
	property p_teo; reset_lamp [*2] |-> time_event == 2'h0; endproperty
	a_teo: assert property (p_teo) else $error("time event in reset");
	property p_stop; reset_lamp |-> !timer_run; endproperty
	a_stop: assert property (p_stop) else $error("timer runs in reset");
	property p_bmp; !$past(reset_lamp) |-> ctrl_out == $past(pid_out); endproperty
	a_bmp: assert property (p_bmp) else $error("output bumped");
	property p_hpr; hold_lamp |-> !reset_lamp; endproperty
	a_hpr: assert property (p_hpr) else $error("hold outside program");
	property p_hsp; hold_lamp [*2] |-> $stable(active_sp); endproperty
	a_hsp: assert property (p_hsp) else $error("setpoint moved in hold");
	property p_hte; hold_lamp [*3] |-> $stable(time_event); endproperty
	a_hte: assert property (p_hte) else $error("time event moved in hold");
	property p_htm; hold_lamp |-> !timer_run; endproperty
	a_htm: assert property (p_htm) else $error("timer runs in hold");
endmodule
bind prs_sequencer prs_seq_asserts prs_seq_asserts_inst (.pclk, .presetn, .pid_out,
	.ctrl_out, .active_sp, .pv_event, .time_event, .hold_lamp, .reset_lamp, .timer_run);

// ===== test/prs_panel_model.sv
// panel, contact and host request model with a moving engine
`timescale 1ns/1ps
module prs_panel_model (
	input  wire logic              pclk,
	input  wire logic              go,
	input  wire logic [1:0]        pick,
	input  wire prs_pkg::prs_req_s bits,
	output prs_pkg::prs_req_s      key_req,
	output prs_pkg::prs_req_s      contact_req,
	output prs_pkg::prs_req_s      comm_req,
	output logic [15:0]            pid_out,
	output logic [15:0]            ramp_sp
);
	import prs_pkg::*;
	initial begin
		{key_req, contact_req, comm_req, pid_out, ramp_sp} = '0;
		forever @(posedge pclk) begin
			key_req <= (go && pick == 2'h0) ? bits : '0;
			contact_req <= (go && pick == 2'h1) ? bits : '0;
			comm_req <= (go && pick == 2'h2) ? bits : '0;
			pid_out <= pid_out + 16'h0101;
			ramp_sp <= ramp_sp + 16'h0003;
		end
	end
endmodule

// ===== test/prs_sequencer_tb.sv
// self-checking bench for the program run mode sequencer
`timescale 1ns/1ps
`include "prs_params.svh"
module prs_sequencer_tb;
	import prs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go, kmr, ufk, se;
	logic        hold_lamp, reset_lamp, manual_mode, timer_run, pid_run;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, t1;
	logic [15:0] pid_out, ramp_sp, ctrl_out, active_sp, pre;
	logic [1:0]  pick, pv_in, te_in, pv_event, time_event;
	logic [2:0]  pid_group;
	logic [4:0]  segment;
	prs_req_s    bits, key_req, contact_req, comm_req;
	int          err_total, n_tests, m_mode, m_hold, m_seg, m_rend;
	prs_sequencer prs_sequencer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .key_req, .key_mode_reset(kmr), .contact_req,
		.comm_req, .ufk_is_reset(ufk), .pid_out, .ramp_sp, .pv_event_in(pv_in),
		.time_event_in(te_in), .ctrl_out, .active_sp, .pid_group, .pv_event, .time_event,
		.segment, .hold_lamp, .reset_lamp, .manual_mode, .pid_run, .timer_run);
	prs_panel_model prs_panel_model_inst (.pclk, .go, .pick, .bits, .key_req, .contact_req,
		.comm_req, .pid_out, .ramp_sp);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		repeat (90000) @(posedge pclk);
		err_total++;
		give_verdict();
	end
	task automatic give_verdict;
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	// model: last segment 3 junctions to local, repeat goes back to 1
	task automatic upd(input int b);
		if (b == 32 || b == 8) m_seg = 1;
		if (b == 32) m_mode = 0;
		if (b == 8) m_mode = 2;
		if (b == 16 && m_mode != 1) begin
			m_mode = 1;
			m_seg = 1;
		end
		if (b == 1 && m_mode == 1) begin
			m_mode = m_seg == 3 ? 2 : 1;
			m_seg = (m_seg == 3 || m_seg == m_rend) ? 1 : m_seg + 1;
		end
		if (b == 4 && m_mode == 1) m_hold = 1;
		if (b == 2 || b == 1 || m_mode != 1) m_hold = 0;
	endtask
	task automatic send(input int src, input int b);
		@(posedge pclk);
		pick <= 2'(src);
		bits <= prs_req_s'(6'(b));
		go <= src != 3;
		kmr <= src == 3;
		@(posedge pclk);
		go <= 1'b0;
		kmr <= 1'b0;
		repeat (5) @(posedge pclk);
		if (src != 3 || !ufk) upd(b);
	endtask
	task automatic st;
		apb(1'b0, `PRS_A_STATUS, 32'h0);
		chk("status", {hold_lamp, reset_lamp, segment, rd[7:0]},
			{m_hold == 1, m_mode == 0, 5'(m_seg), 5'(m_seg), m_hold == 1, 2'(m_mode)});
		chk("run", pid_run, m_mode != 0);
		chk("tevent", time_event, m_mode == 1 ? te_in : 2'h0);
		chk("pvevent", pv_event, m_mode == 0 ? 2'h0 : pv_in);
	endtask
	initial begin
		void'($urandom(32'h19D0E213));
		{psel, penable, pwrite, go, kmr, ufk, presetn, paddr, pwdata, pick, bits} = '0;
		{err_total, n_tests, m_mode, m_hold, m_rend} = '0;
		m_seg = 1;
		pv_in = 2'($urandom);
		te_in = 2'($urandom);
		pre = 16'($urandom);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		st();
		apb(1'b1, `PRS_A_PRESET, {16'h0, pre});
		apb(1'b1, `PRS_A_SEGCFG, {5'h03, 5'h02, 5'h01, 1'b1, 16'hFFFF});
		m_rend = 2;
		send(2, 4);
		send(0, 1);
		st();
		send($urandom_range(2), 16);
		st();
		send(1, 4);
		st();
		apb(1'b0, `PRS_A_TIMER, 32'h0);
		t1 = rd;
		repeat (25000) @(posedge pclk);
		apb(1'b0, `PRS_A_TIMER, 32'h0);
		chk("frozen", rd, t1);
		send(1, 2);
		st();
		repeat (25000) @(posedge pclk);
		apb(1'b0, `PRS_A_TIMER, 32'h0);
		chk("resumed", rd < t1 && rd + 3 > t1, 1);
		send(1, 4);
		send(0, 1);
		st();
		send(2, 1);
		st();
		apb(1'b1, `PRS_A_SEGCFG, {5'h03, 5'h00, 5'h01, 1'b1, 16'hFFFF});
		m_rend = 0;
		repeat (2) send(0, 1);
		apb(1'b1, `PRS_A_CTRL, 32'h20);
		upd(1);
		st();
		apb(1'b0, `PRS_A_CTRL, 32'h0);
		chk("adv", rd[5], 0);
		apb(1'b1, `PRS_A_CTRL, 32'hB00);
		chk("local pid", pid_group, 5);
		ufk <= 1'b1;
		send(3, 32);
		st();
		ufk <= 1'b0;
		send(3, 32);
		st();
		apb(1'b1, `PRS_A_CTRL, 32'h5080);
		chk("seg pid", pid_group, 1);
		apb(1'b1, `PRS_A_CTRL, 32'h40);
		chk("manual", manual_mode, 1);
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, `PRS_A_CTRL, 32'(c + 4));
			upd(32 >> c);
			st();
		end
		send(2, 16);
		send(2, 32);
		chk("preset", ctrl_out, pre);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped", {se, rd[30:0]}, 32'h80000000);
		give_verdict();
	end
endmodule
